// ==== tmr8_defines.svh ====
`ifndef TMR8_DEFINES_SVH
`define TMR8_DEFINES_SVH

// register byte offsets
`define TMR8_OFF_CTRL 12'h000
`define TMR8_OFF_COUNT 12'h004
`define TMR8_OFF_CMP 12'h008
`define TMR8_OFF_FLAG 12'h00C
`define TMR8_OFF_MASK 12'h010
`define TMR8_OFF_STAT 12'h014

// control register fields
`define TMR8_CS_LSB 0
`define TMR8_CS_MSB 2
`define TMR8_WGM_LSB 3
`define TMR8_WGM_MSB 4
`define TMR8_COM_LSB 5
`define TMR8_COM_MSB 6
`define TMR8_FOC_BIT 7

// flag and mask bit positions
`define TMR8_OVF_BIT 0
`define TMR8_CMF_BIT 1

// values
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hFF
`define TMR8_RST_BYTE 8'h00

// prescaler taps in system clocks
`define TMR8_PRE_W 10
`define TMR8_PRE_8 10'h007
`define TMR8_PRE_64 10'h03F
`define TMR8_PRE_256 10'h0FF
`define TMR8_PRE_1024 10'h3FF

`endif

// ==== tmr8_pkg.sv ====
package tmr8_pkg;
  typedef enum logic [1:0] {
    TMR8_WGM_NORMAL,
    TMR8_WGM_PHASE,
    TMR8_WGM_CTC,
    TMR8_WGM_FAST
  } tmr8_wgm_t;

  typedef enum logic [2:0] {
    TMR8_CS_STOP,
    TMR8_CS_DIV1,
    TMR8_CS_DIV8,
    TMR8_CS_DIV64,
    TMR8_CS_DIV256,
    TMR8_CS_DIV1024,
    TMR8_CS_EXT_FALL,
    TMR8_CS_EXT_RISE
  } tmr8_cs_t;

  typedef enum logic [1:0] {
    TMR8_AHB_IDLE,
    TMR8_AHB_DATA
  } tmr8_ahb_t;
endpackage : tmr8_pkg

// ==== tmr8_prescaler.sv ====
`timescale 1ns/100ps
`include "tmr8_defines.svh"

module tmr8_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] sel_i,
  input wire logic ext_sync_i,
  output logic tick_o
);
  logic [`TMR8_PRE_W-1:0] div_q;
  logic ext_prev_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_sync_i;
    end
  end

  // source and edge choice form one tick per period
  always_comb begin
    case (tmr8_pkg::tmr8_cs_t'(sel_i))
      tmr8_pkg::TMR8_CS_STOP: tick_o = 1'b0;
      tmr8_pkg::TMR8_CS_DIV1: tick_o = 1'b1;
      tmr8_pkg::TMR8_CS_DIV8:
        tick_o = (div_q[2:0] == 3'h7);
      tmr8_pkg::TMR8_CS_DIV64: tick_o = (div_q[5:0] == 6'h3F);
      tmr8_pkg::TMR8_CS_DIV256: tick_o = (div_q[7:0] == 8'hFF);
      tmr8_pkg::TMR8_CS_DIV1024: tick_o = (div_q == `TMR8_PRE_1024);
      tmr8_pkg::TMR8_CS_EXT_FALL: tick_o = ext_prev_q & ~ext_sync_i;
      tmr8_pkg::TMR8_CS_EXT_RISE: tick_o = ~ext_prev_q & ext_sync_i;
      default: tick_o = 1'b0;
    endcase
  end
endmodule : tmr8_prescaler

// ==== tmr8_waveform.sv ====
`timescale 1ns/100ps
`include "tmr8_defines.svh"

module tmr8_waveform (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] wgm_i,
  input wire logic [1:0] com_i,
  input wire logic tick_i,
  input wire logic match_i,
  input wire logic force_i,
  input wire logic at_bottom_i,
  input wire logic up_i,
  output logic oc_o
);
  logic oc_q;
  logic is_pwm;

  assign is_pwm = (wgm_i == tmr8_pkg::TMR8_WGM_PHASE) ||
                  (wgm_i == tmr8_pkg::TMR8_WGM_FAST);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_q <= 1'b0;
    end else if (com_i != 2'h0) begin
      if (!is_pwm && (force_i || (tick_i && match_i))) begin
        // non-pwm: toggle, clear or set on match
        case (com_i)
          2'h1: oc_q <= ~oc_q;
          2'h2: oc_q <= 1'b0;
          2'h3: oc_q <= 1'b1;
          default: oc_q <= oc_q;
        endcase
      end else if (is_pwm && tick_i && com_i[1]) begin
        if (wgm_i == tmr8_pkg::TMR8_WGM_FAST) begin
          if (match_i) begin
            oc_q <= com_i[0];
          end else if (at_bottom_i) begin
            oc_q <= ~com_i[0];
          end
        end else if (match_i) begin
          // phase correct: direction picks the level
          oc_q <= up_i ? com_i[0] : ~com_i[0];
        end
      end
    end
  end

  assign oc_o = oc_q;
endmodule : tmr8_waveform

// ==== tmr8_timer.sv ====
`timescale 1ns/100ps
`include "tmr8_defines.svh"

module tmr8_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic external_count_pin_i,
  input wire logic ovf_ack_i,
  input wire logic cmp_ack_i,
  output logic compare_output_pin_o,
  output logic compare_output_en_o,
  output logic ovf_irq_o,
  output logic cmp_irq_o
);
  logic [7:0] ctrl_q;
  logic [7:0] count_value_q;
  logic [7:0] compare_value_a_q;
  logic [7:0] cmp_buf_q;
  logic [1:0] flag_q;
  logic [1:0] mask_q;
  logic up_q;
  logic match_d_q;
  logic block_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic wr_pend_q;
  logic [11:0] addr_q;
  logic tick;
  logic [2:0] cs;
  logic [1:0] wgm;
  logic [1:0] com;
  logic is_pwm;
  logic match;
  logic [7:0] top;
  logic at_top;
  logic at_bottom;
  logic wr_en;
  logic wr_count;
  logic wr_ctrl;
  logic force_cmp;
  logic ovf_set;
  logic cmf_set;
  logic [7:0] wdat;
  logic wr_cmp;
  logic wr_flag;
  logic wr_mask;
  logic rd_take;
  logic [7:0] ctrl_view;
  logic [7:0] count_view;
  logic [7:0] cmp_view;
  logic [1:0] flag_view;
  logic [1:0] mask_view;

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  assign cs = ctrl_q[`TMR8_CS_MSB:`TMR8_CS_LSB];
  assign wgm = ctrl_q[`TMR8_WGM_MSB:`TMR8_WGM_LSB];
  assign com = ctrl_q[`TMR8_COM_MSB:`TMR8_COM_LSB];
  assign is_pwm = (wgm == tmr8_pkg::TMR8_WGM_PHASE) ||
                  (wgm == tmr8_pkg::TMR8_WGM_FAST);

  // ahb-lite slave, zero wait states, writes land in data phase
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign wr_en = wr_pend_q;
  assign wdat = hwdata_i[7:0];
  assign wr_count = wr_en && addr_is(addr_q, `TMR8_OFF_COUNT);
  assign wr_ctrl = wr_en && addr_is(addr_q, `TMR8_OFF_CTRL);
  assign force_cmp = wr_ctrl && wdat[`TMR8_FOC_BIT];
  assign wr_cmp = wr_en && addr_is(addr_q, `TMR8_OFF_CMP);
  assign wr_flag = wr_en && addr_is(addr_q, `TMR8_OFF_FLAG);
  assign wr_mask = wr_en && addr_is(addr_q, `TMR8_OFF_MASK);
  assign rd_take = hready_i && hsel_i && htrans_i[1] && !hwrite_i;

  // a read whose address phase meets a write's data phase must see the
  // new value, so the pending write is forwarded into the read view
  always_comb begin
    ctrl_view = {1'b0, ctrl_q[6:0]};
    count_view = count_value_q;
    cmp_view = is_pwm ? cmp_buf_q : compare_value_a_q;
    flag_view = flag_q;
    mask_view = mask_q;
    if (wr_ctrl) begin
      ctrl_view = {1'b0, wdat[6:0]};
    end
    if (wr_count) begin
      count_view = wdat;
    end
    if (wr_cmp) begin
      cmp_view = wdat;
    end
    if (wr_flag) begin
      // a flag set in that same cycle shows on the next read
      flag_view = flag_q & ~wdat[1:0];
    end
    if (wr_mask) begin
      mask_view = wdat[1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else if (hready_i) begin
      wr_pend_q <= hsel_i && htrans_i[1] && hwrite_i;
      addr_q <= haddr_i;
    end
  end

  // read data registered at address phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_o <= 32'h0000_0000;
      if (addr_is(haddr_i, `TMR8_OFF_CTRL)) begin
        hrdata_o[6:0] <= ctrl_view[6:0];
      end else if (addr_is(haddr_i, `TMR8_OFF_COUNT)) begin
        hrdata_o[7:0] <= count_view;
      end else if (addr_is(haddr_i, `TMR8_OFF_CMP)) begin
        hrdata_o[7:0] <= cmp_view;
      end else if (addr_is(haddr_i, `TMR8_OFF_FLAG)) begin
        hrdata_o[1:0] <= flag_view;
      end else if (addr_is(haddr_i, `TMR8_OFF_MASK)) begin
        hrdata_o[1:0] <= mask_view;
      end else if (addr_is(haddr_i, `TMR8_OFF_STAT)) begin
        hrdata_o[1:0] <= {up_q, compare_output_pin_o};
      end
    end
  end

  // external pin enters through two flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= external_count_pin_i;
      ext_s2_q <= ext_s1_q;
    end
  end

  tmr8_prescaler tmr8_prescaler_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(cs),
    .ext_sync_i(ext_s2_q),
    .tick_o(tick)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `TMR8_RST_BYTE;
      mask_q <= 2'h0;
    end else if (wr_en) begin
      if (wr_ctrl) begin
        ctrl_q <= {1'b0, wdat[6:0]}; // strobe bit never stored
      end
      if (addr_is(addr_q, `TMR8_OFF_MASK)) begin
        mask_q <= wdat[1:0];
      end
    end
  end

  // compare register: buffered in pwm, direct otherwise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_buf_q <= `TMR8_RST_BYTE;
      compare_value_a_q <= `TMR8_RST_BYTE;
    end else begin
      if (wr_en && addr_is(addr_q, `TMR8_OFF_CMP)) begin
        cmp_buf_q <= wdat;
        if (!is_pwm) begin
          compare_value_a_q <= wdat;
        end
      end
      // update at top in both phase and fast modes
      if (is_pwm && tick && !wr_count) begin
        if ((wgm == tmr8_pkg::TMR8_WGM_PHASE && at_top) ||
            (wgm == tmr8_pkg::TMR8_WGM_FAST && at_top)) begin
          compare_value_a_q <= cmp_buf_q;
        end
      end
    end
  end

  assign match = (count_value_q == compare_value_a_q);
  // ctc tops at compare, all others at max
  assign top = (wgm == tmr8_pkg::TMR8_WGM_CTC) ?
               compare_value_a_q : `TMR8_MAX;
  assign at_top = (count_value_q == top);
  assign at_bottom = (count_value_q == `TMR8_BOTTOM);

  // counter: software write overrides everything
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_value_q <= `TMR8_RST_BYTE;
      up_q <= 1'b1;
    end else if (wr_count) begin
      count_value_q <= wdat;
    end else if (tick) begin
      case (tmr8_pkg::tmr8_wgm_t'(wgm))
        tmr8_pkg::TMR8_WGM_CTC: begin
          count_value_q <= at_top ? `TMR8_BOTTOM :
                           count_value_q + 8'h01;
        end
        tmr8_pkg::TMR8_WGM_PHASE: begin
          if (up_q && at_top) begin
            up_q <= 1'b0;
            count_value_q <= count_value_q - 8'h01;
          end else if (!up_q && at_bottom) begin
            up_q <= 1'b1;
            count_value_q <= count_value_q + 8'h01;
          end else begin
            count_value_q <= up_q ? count_value_q + 8'h01 :
                             count_value_q - 8'h01;
          end
        end
        default: begin
          up_q <= 1'b1;
          count_value_q <= count_value_q + 8'h01;
        end
      endcase
    end
  end

  // a count write blocks the match on the next tick
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      block_q <= 1'b0;
      match_d_q <= 1'b0;
    end else begin
      if (wr_count) begin
        block_q <= 1'b1;
      end else if (tick) begin
        block_q <= 1'b0;
      end
      if (tick) begin
        match_d_q <= match && !block_q && !wr_count;
      end
    end
  end

  // flag set one tick after the match was seen
  assign cmf_set = tick && match_d_q && !wr_count;
  // overflow at wrap from max, or at bottom in phase mode
  assign ovf_set = tick && !wr_count &&
    ((wgm == tmr8_pkg::TMR8_WGM_PHASE) ? (!up_q && at_bottom) :
     (count_value_q == `TMR8_MAX));

  // set beats clear; write one or ack clears
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `TMR8_OVF_BIT) ? ovf_set : cmf_set) begin
          flag_q[i] <= 1'b1;
        end else if ((wr_en && addr_is(addr_q, `TMR8_OFF_FLAG) &&
                      wdat[i]) ||
                     ((i == `TMR8_OVF_BIT) ? ovf_ack_i : cmp_ack_i)) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  assign ovf_irq_o = flag_q[`TMR8_OVF_BIT] && mask_q[`TMR8_OVF_BIT];
  assign cmp_irq_o = flag_q[`TMR8_CMF_BIT] && mask_q[`TMR8_CMF_BIT];
  assign compare_output_en_o = (com != 2'h0);

  tmr8_waveform tmr8_waveform_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wgm_i(wgm),
    .com_i(com),
    .tick_i(tick && !block_q),
    .match_i(match),
    .force_i(force_cmp),
    .at_bottom_i(at_bottom),
    .up_i(up_q),
    .oc_o(compare_output_pin_o)
  );
endmodule : tmr8_timer

// ==== tmr8_timer_properties.sv ====
`timescale 1ns/100ps
`include "tmr8_defines.svh"
module tmr8_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic external_count_pin_i,
  input wire logic ovf_ack_i,
  input wire logic cmp_ack_i,
  input wire logic compare_output_pin_o,
  input wire logic compare_output_en_o,
  input wire logic ovf_irq_o,
  input wire logic cmp_irq_o
);
  logic ap;
  logic wr_ctrl_q;
  logic wr_mask_q;
  assign ap = hsel_i && htrans_i[1] && hready_i;
  // remembers the address phase so data-phase writes can be recognised
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ctrl_q <= 1'b0;
      wr_mask_q <= 1'b0;
    end else begin
      wr_ctrl_q <= ap && hwrite_i && haddr_i == `TMR8_OFF_CTRL;
      wr_mask_q <= ap && hwrite_i && haddr_i == `TMR8_OFF_MASK;
    end
  end
  sequence ctrl_wr_s;
    ap && hwrite_i && haddr_i == `TMR8_OFF_CTRL ##1 1'b1;
  endsequence
  ready_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hreadyout_o) else $error("ready dropped");
  resp_okay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !hresp_o) else $error("error response");
  rdata_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(hrdata_o) |-> $past(ap && !hwrite_i))
    else $error("read data moved without a read");
  oe_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(compare_output_en_o) |-> $past(wr_ctrl_q))
    else $error("output enable moved without a control write");
  oe_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr_s |=> compare_output_en_o == ($past(hwdata_i[6:5]) != 2'h0))
    else $error("output enable does not follow output action");
  ovf_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mask_q && !hwdata_i[`TMR8_OVF_BIT] |=> !ovf_irq_o)
    else $error("masked overflow request still raised");
  cmp_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mask_q && !hwdata_i[`TMR8_CMF_BIT] |=> !cmp_irq_o)
    else $error("masked compare request still raised");
  // checked during reset itself, so no disable here
  reset_clear_a: assert property (@(posedge clk_i) rst_i |->
    !ovf_irq_o && !cmp_irq_o && !compare_output_en_o && hrdata_o == 32'h0)
    else $error("outputs not cleared in reset");
endmodule : tmr8_props

bind tmr8_timer tmr8_props tmr8_props_i (.clk_i(clk_i), .rst_i(rst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .external_count_pin_i(external_count_pin_i),
  .ovf_ack_i(ovf_ack_i), .cmp_ack_i(cmp_ack_i),
  .compare_output_pin_o(compare_output_pin_o),
  .compare_output_en_o(compare_output_en_o), .ovf_irq_o(ovf_irq_o),
  .cmp_irq_o(cmp_irq_o));

// ==== test_tmr8_timer.sv ====
`timescale 1ns/100ps
`include "tmr8_defines.svh"
module test_tmr8_timer;
  logic clk_i = 1'b0;
  logic rst_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [11:0] haddr_i = 12'h000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h00000000;
  logic ext_i = 1'b0;
  logic ovf_ack_i = 1'b0;
  logic cmp_ack_i = 1'b0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic pin_o;
  logic en_o;
  logic ovf_irq_o;
  logic cmp_irq_o;
  logic [31:0] r;
  int errors = 0;
  int compares = 0;
  always #5 clk_i = ~clk_i;
  tmr8_timer tmr8_timer_i (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .external_count_pin_i(ext_i), .ovf_ack_i(ovf_ack_i),
    .cmp_ack_i(cmp_ack_i), .compare_output_pin_o(pin_o),
    .compare_output_en_o(en_o), .ovf_irq_o(ovf_irq_o),
    .cmp_irq_o(cmp_irq_o));
  task print_verdict;
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task wait_rdy;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
  endtask : wait_rdy
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    wait_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy();
    r = hrdata_o;
  endtask : ahb
  task wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk_word(r, e);
  endtask : rd
  task t_reset;
    rd(`TMR8_OFF_COUNT, 32'h0);
    rd(`TMR8_OFF_CMP, 32'h0);
    rd(`TMR8_OFF_FLAG, 32'h0);
    rd(`TMR8_OFF_MASK, 32'h0);
    rd(12'h020, 32'h0);
  endtask : t_reset
  task t_stop;
    wr(`TMR8_OFF_COUNT, 32'h123456A5);
    repeat (20) @(posedge clk_i);
    rd(`TMR8_OFF_COUNT, 32'h000000A5);
  endtask : t_stop
  task t_ovf;
    wr(`TMR8_OFF_MASK, 32'h1);
    wr(`TMR8_OFF_COUNT, 32'hFD);
    wr(`TMR8_OFF_CTRL, 32'h01);
    repeat (10) @(posedge clk_i);
    chk_word({31'h0, ovf_irq_o}, 32'h1);
    rd(`TMR8_OFF_FLAG, 32'h3);
    ovf_ack_i <= 1'b1;
    @(posedge clk_i);
    ovf_ack_i <= 1'b0;
    @(posedge clk_i);
    chk_word({31'h0, ovf_irq_o}, 32'h0);
    wr(`TMR8_OFF_CTRL, 32'h00);
    wr(`TMR8_OFF_FLAG, 32'h3);
    rd(`TMR8_OFF_FLAG, 32'h0);
  endtask : t_ovf
  task t_ctc;
    int n;
    logic p;
    wr(`TMR8_OFF_COUNT, 32'h0);
    wr(`TMR8_OFF_CMP, 32'h5);
    wr(`TMR8_OFF_MASK, 32'h2);
    wr(`TMR8_OFF_CTRL, 32'h31);
    #1;
    chk_word({31'h0, en_o}, 32'h1);
    repeat (8) begin
      ahb(1'b0, `TMR8_OFF_COUNT, 32'h0);
      chk_word({31'h0, r < 32'h6}, 32'h1);
    end
    n = 0;
    p = pin_o;
    // output toggles every six ticks, so twenty cycles see several edges
    repeat (20) begin
      @(posedge clk_i);
      if (pin_o !== p) n++;
      p = pin_o;
    end
    chk_word({31'h0, n > 2}, 32'h1);
    chk_word({31'h0, cmp_irq_o}, 32'h1);
    wr(`TMR8_OFF_CTRL, 32'h30);
    wr(`TMR8_OFF_FLAG, 32'h2);
    #1;
    chk_word({31'h0, cmp_irq_o}, 32'h0);
    wr(`TMR8_OFF_MASK, 32'h0);
  endtask : t_ctc
  task t_pre;
    wr(`TMR8_OFF_CTRL, 32'h00);
    wr(`TMR8_OFF_COUNT, 32'h0);
    wr(`TMR8_OFF_CTRL, 32'h02);
    repeat (80) @(posedge clk_i);
    wr(`TMR8_OFF_CTRL, 32'h00);
    ahb(1'b0, `TMR8_OFF_COUNT, 32'h0);
    // prescaler phase is free running, hence a window
    chk_word({31'h0, r >= 32'h9 && r <= 32'hC}, 32'h1);
  endtask : t_pre
  task t_ext(input logic [31:0] cs);
    wr(`TMR8_OFF_COUNT, 32'h0);
    wr(`TMR8_OFF_CTRL, cs);
    repeat (4) begin
      ext_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      ext_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
    wr(`TMR8_OFF_CTRL, 32'h00);
    rd(`TMR8_OFF_COUNT, 32'h4);
  endtask : t_ext
  task t_pwm;
    int n;
    logic p;
    wr(`TMR8_OFF_CMP, 32'h80);
    wr(`TMR8_OFF_CTRL, 32'h49);
    wr(`TMR8_OFF_CMP, 32'h33);
    rd(`TMR8_OFF_CMP, 32'h33);
    n = 0;
    p = pin_o;
    repeat (1100) begin
      @(posedge clk_i);
      if (pin_o !== p) n++;
      p = pin_o;
    end
    chk_word({31'h0, n > 1}, 32'h1);
    wr(`TMR8_OFF_CTRL, 32'h00);
  endtask : t_pwm
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
  initial begin
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_stop();
    t_ovf();
    t_ctc();
    t_pre();
    t_ext(32'h07);
    t_ext(32'h06);
    t_pwm();
    print_verdict();
  end
endmodule : test_tmr8_timer
